// ### bench/adc_cal_control_asserts.sv
// Port-level checks of the calibration control
`timescale 1ns/1ps
module adc_cal_control_asserts #(
  parameter CAL_NOM_CYCLES = 50,
  parameter CAL_MAX_CYCLES = 100
) (
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic recal_trigger_n_in, // Recal wire
  input wire logic recal_trigger_n_oe, // Recal enable
  input wire logic supply_ok, // Supply good
  input wire logic conv_valid, // Raw valid
  input wire logic core_a_strobe, // Core A
  input wire logic core_b_strobe, // Core B
  input wire logic input_connect, // Input on
  input wire logic output_clock_pair, // Out clock
  input wire logic [9:0] sample_out, // Sample
  input wire logic sample_valid, // Valid
  input wire logic over_range // Over-range
);
  logic last_a;
  logic [31:0] since_rise;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      last_a <= 1'h0;
      since_rise <= 32'h0;
    end else begin
      if (core_a_strobe | core_b_strobe)
        last_a <= core_a_strobe;
      since_rise <= recal_trigger_n_in ? since_rise + 32'h1 : 32'h0;
    end
  end
  AST_CORES_EXCL: assert property (!(core_a_strobe && core_b_strobe))
    else $error("both cores strobed");
  AST_CORES_ALT: assert property (core_a_strobe |-> !last_a)
    else $error("core A strobed twice in a row");
  AST_LATENCY: assert property (sample_valid |-> $past(conv_valid, 15))
    else $error("sample without input fifteen cycles earlier");
  AST_SATURATE: assert property (sample_valid |-> over_range == (sample_out == 10'h3FF))
    else $error("over-range does not match full scale");
  AST_OR_HELD: assert property (!recal_trigger_n_in [*8] |-> over_range)
    else $error("over-range low while recal held");
  AST_OUTCLK_LOW: assert property (!recal_trigger_n_in [*8] |-> !output_clock_pair)
    else $error("output clock runs while recal held");
  AST_INPUT_OFF: assert property (sample_valid |-> input_connect)
    else $error("samples while input disconnected");
  AST_CAL_TIME: assert property ($rose(input_connect) |->
    since_rise >= CAL_NOM_CYCLES && since_rise <= CAL_MAX_CYCLES)
    else $error("calibration length out of range");
  AST_POR_WAIT: assert property ($rose(recal_trigger_n_oe) |-> $past(supply_ok, 16))
    else $error("recal released before supply stable");
endmodule // adc_cal_control_asserts
bind adc_cal_control adc_cal_control_asserts #(
  .CAL_NOM_CYCLES(CAL_NOM_CYCLES), .CAL_MAX_CYCLES(CAL_MAX_CYCLES)
) adc_cal_control_asserts_i (.core_clk(core_clk), .rstn(rstn),
  .recal_trigger_n_in(recal_trigger_n_in), .recal_trigger_n_oe(recal_trigger_n_oe),
  .supply_ok(supply_ok), .conv_valid(conv_valid), .core_a_strobe(core_a_strobe),
  .core_b_strobe(core_b_strobe), .input_connect(input_connect),
  .output_clock_pair(output_clock_pair), .sample_out(sample_out),
  .sample_valid(sample_valid), .over_range(over_range));

// ### bench/adc_cal_control_tb.sv
// Self-checking bench for the calibration control
`timescale 1ns/1ps
`include "adc_cal_map.vh"
module adc_cal_control_tb;
  localparam int NOM = 50;
  localparam int MAX = 100;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic supply_ok = 1'h0;
  logic sdo_low = 1'h0;
  logic div_lo = 1'h0;
  logic div_hi = 1'h0;
  logic [10:0] code = 11'h200;
  logic core = 1'h0;
  logic cval = 1'h1;
  logic go = 1'h0;
  logic [3:0] len = 4'h1;
  logic [31:0] rdata, r;
  logic pin, pin_out, pin_oe, sline, a_stb, b_stb, conn, oclk, valid, ovr;
  logic [7:0] skew;
  logic [9:0] sample;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  adc_cal_control #(.CAL_NOM_CYCLES(NOM), .CAL_MAX_CYCLES(MAX)) adc_cal_control_i (
    .core_clk(core_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .recal_trigger_n_in(pin), .recal_trigger_n_out(pin_out),
    .recal_trigger_n_oe(pin_oe), .supply_ok(supply_ok), .serial_out_line_in(sline),
    .divider_select_low(div_lo), .divider_select_high(div_hi), .conv_code(code),
    .conv_core(core), .conv_valid(cval), .core_a_strobe(a_stb), .core_b_strobe(b_stb),
    .input_connect(conn), .skew_trim(skew), .output_clock_pair(oclk),
    .sample_out(sample), .sample_valid(valid), .over_range(ovr));
  recal_host recal_host_i (.core_clk(core_clk), .dev_out(pin_out), .dev_oe(pin_oe),
    .go(go), .len(len), .sdo_low(sdo_low), .pin(pin), .serial_line(sline));
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) core <= ~core;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge core_clk);
    rd <= 1'h0;
    #1 r = rdata;
  endtask
  // Waits for the input to reconnect, n = cycles spent
  task wait_cal;
    n = 0;
    while (conn !== 1'h1 && n < 400) begin
      tick(1);
      n++;
    end
    chk(n <= MAX, 1);
    tick(3);
    chk(ovr, 0);
    r[0] = oclk;
    tick(1);
    chk(oclk, !r[0]);
  endtask
  task t_por;
    tick(30);
    chk(pin_oe, 0);
    chk(ovr, 1);
    chk(oclk, 0);
    @(posedge core_clk);
    supply_ok <= 1'h1;
    n = 0;
    while (pin_oe !== 1'h1 && n < 60) begin
      tick(1);
      n++;
    end
    chk(n > 15 && n < 40, 1);
    tick(8);
    chk(conn, 0);
    wait_cal();
    rd_reg(`REG_STATUS);
    chk(r[5:1], 5'h11);
    $display("power-up test done");
  endtask
  task t_regs;
    wr_reg(`REG_TRIM, 32'hA5000000);
    wr_reg(`REG_CALOFS, 32'hFFFF);
    tick(2);
    chk(skew, 8'hA5);
    rd_reg(`REG_TRIM);
    chk(r, 32'hA5000000);
    rd_reg(8'h10);
    chk(r, 0);
    rd_reg(`REG_CALOFS);
    chk(r, 0);
    tick(1);
    chk(rdata, 0);
    $display("register test done");
  endtask
  task send(input logic [10:0] c, input logic [9:0] e, input logic o);
    @(posedge core_clk);
    code <= c;
    @(posedge core_clk);
    code <= 11'h200;
    cval <= 1'h0;
    @(posedge core_clk);
    cval <= 1'h1;
    tick(12);
    chk(sample, 10'h200);
    tick(1);
    chk({valid, ovr, sample}, {1'h1, o, e});
    tick(1);
    chk({valid, sample}, {1'h0, 10'h200});
  endtask
  task t_stream;
    send(11'h155, 10'h155, 1'h0);
    send(11'h3FE, 10'h3FE, 1'h0);
    send(11'h3FF, 10'h3FF, 1'h1);
    send(11'h7FF, 10'h3FF, 1'h1);
    $display("stream test done");
  endtask
  task count_stb(input int e);
    tick(8);
    n = 0;
    repeat (20) begin
      tick(1);
      n += a_stb + b_stb;
    end
    chk(n, e);
  endtask
  task t_div;
    @(posedge core_clk);
    div_lo <= 1'h1;
    count_stb(10);
    rd_reg(`REG_STATUS);
    chk(r[4], 1);
    @(posedge core_clk) div_lo <= 1'h0;
    count_stb(20);
    @(posedge core_clk) div_hi <= 1'h1;
    count_stb(20);
    rd_reg(`REG_STATUS);
    chk(r[4:3], 2'h1);
    @(posedge core_clk) div_hi <= 1'h0;
    wr_reg(`REG_CTRL, 32'h3);
    count_stb(10);
    // A slipped phase shows as two strobes in a row
    wr_reg(`REG_CTRL, 32'hB);
    n = 0;
    r[0] = 1'h0;
    repeat (8) begin
      tick(1);
      n += (a_stb | b_stb) & r[0];
      r[0] = a_stb | b_stb;
    end
    chk(n, 1);
    @(posedge core_clk) div_lo <= 1'h1;
    wr_reg(`REG_CTRL, 32'h1);
    count_stb(20);
    rd_reg(`REG_CTRL);
    chk(r, 1);
    wr_reg(`REG_CTRL, 32'h0);
    div_lo <= 1'h0;
    $display("divider test done");
  endtask
  task t_recal(input logic bad, input logic [3:0] l);
    @(posedge core_clk);
    sdo_low <= bad;
    go <= 1'h1;
    len <= l;
    @(posedge core_clk);
    go <= 1'h0;
    tick(8);
    if (l > 8) chk(oclk, 0);
    tick(1);
    if (l > 8) chk(oclk, 0);
    tick(l);
    chk({ovr, conn}, 2'h2);
    wait_cal();
    rd_reg(`REG_STATUS);
    chk(r[2], bad);
    $display("recal test done");
  endtask
  task t_soft;
    @(posedge core_clk);
    sdo_low <= 1'h0;
    wr_reg(`REG_CTRL, 32'h4);
    n = 0;
    repeat (8) begin
      tick(1);
      n += (pin_oe === 1'h0);
    end
    chk(n, 4);
    tick(6);
    chk(conn, 0);
    wait_cal();
    chk(skew, 8'hA5);
    rd_reg(`REG_CTRL);
    chk(r, 0);
    $display("soft recal test done");
  endtask
  task end_sim;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'h1;
    t_por();
    t_regs();
    t_stream();
    t_div();
    t_recal(1'h0, 4'h1);
    t_recal(1'h1, 4'hC);
    t_soft();
    end_sim();
  end
endmodule // adc_cal_control_tb

// ### bench/recal_host.sv
// Board host: open-drain recal wire and serial line pull-up
`timescale 1ns/1ps
module recal_host (
  input wire logic core_clk, // Clock
  input wire logic dev_out, // Device drive value
  input wire logic dev_oe, // Device enable, low drives
  input wire logic go, // Start low pulse
  input wire logic [3:0] len, // Pulse cycles
  input wire logic sdo_low, // Pull serial line low
  output wire logic pin, // Recal wire
  output wire logic serial_line // Serial line
);
  logic [3:0] left = 4'h0;
  always @(posedge core_clk) begin
    if (go)
      left <= len;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  // Pull-up unless either party pulls low
  assign pin = (dev_oe | dev_out) & (left == 4'h0);
  assign serial_line = ~sdo_low;
endmodule // recal_host

// ### common/adc_cal_map.vh
// Register map, field positions, reset values and timing counts of the calibration control
`ifndef ADC_CAL_MAP_VH
`define ADC_CAL_MAP_VH

// Register offsets
`define REG_CTRL 8'h00
`define REG_TRIM 8'h04
`define REG_STATUS 8'h08
`define REG_CALOFS 8'h0C

// Control fields
`define CTRL_DIV_OVR_EN 0
`define CTRL_DIV_OVR_TWO 1
`define CTRL_SOFT_RECAL 2
`define CTRL_PHASE_SLIP 3
`define CTRL_RESET 2'h0

// Trim fields
`define TRIM_OFS_A_LSB 0
`define TRIM_OFS_B_LSB 8
`define TRIM_GAIN_LSB 16
`define TRIM_SKEW_LSB 24
`define TRIM_RESET 32'h00000000

// Status fields
`define STAT_CAL_BUSY 0
`define STAT_CAL_DONE 1
`define STAT_CAL_FAULT 2
`define STAT_DIV_ILLEGAL 3
`define STAT_DIV_TWO 4
`define STAT_POR_DONE 5
`define STAT_RECAL_LVL 6

// Conversion pipeline
`define PIPE_SAMPLES 12
`define PIPE_TOTAL 15
`define CODE_MID 11'h200
`define CODE_FULL 10'h3FF
`define OFS_POS_LIM 8'h7F
`define OFS_NEG_LIM 8'h81

// Timing
`define CLK_HZ 10000000
`define CAL_NOM_MS 200
`define CAL_MAX_MS 550
`define CAL_NOM_CYCLES ((`CAL_NOM_MS) * ((`CLK_HZ) / 1000))
`define CAL_MAX_CYCLES ((`CAL_MAX_MS) * ((`CLK_HZ) / 1000))
`define POR_STABLE_CYCLES 16
`define SOFT_RECAL_CYCLES 4'h4

`endif

// ### logic/adc_cal_control.v
// Interleaved converter control: clocking, pipeline, calibration, divider, registers
`timescale 1ns/1ps
`include "adc_cal_map.vh"
module adc_cal_control #(
  parameter CAL_NOM_CYCLES = `CAL_NOM_CYCLES,
  parameter CAL_MAX_CYCLES = `CAL_MAX_CYCLES
) (
  input wire core_clk, // Conversion clock, 10 MHz
  input wire rstn, // Async reset, active low
  input wire [7:0] addr, // Register byte address
  input wire [31:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [31:0] rdata, // Read data, cycle after rd
  input wire recal_trigger_n_in, // Recal pin level
  output reg recal_trigger_n_out, // Recal pin drive value
  output reg recal_trigger_n_oe, // Recal pin enable, low drives
  input wire supply_ok, // Supply above threshold
  input wire serial_out_line_in, // Serial output line level
  input wire divider_select_low, // Divider pin sensed low
  input wire divider_select_high, // Divider pin sensed high
  input wire [10:0] conv_code, // Raw code from a core
  input wire conv_core, // Core that made the code
  input wire conv_valid, // Raw code valid
  output reg core_a_strobe, // Sample strobe, core A
  output reg core_b_strobe, // Sample strobe, core B
  output reg input_connect, // Analog input to sampling stage
  output reg [7:0] skew_trim, // Skew adjust to clock tree
  output reg output_clock_pair, // Output clock
  output reg [9:0] sample_out, // Corrected sample
  output reg sample_valid, // Sample valid
  output reg over_range // Over-range flag
);
  localparam ST_IDLE = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_RUN = 2'h2;

  wire [4:0] sync_q;
  wire recal_lvl = sync_q[0];
  wire supply_lvl = sync_q[1];
  wire sdo_lvl = sync_q[2];
  wire div_low_lvl = sync_q[3];
  wire div_high_lvl = sync_q[4];

  reg [1:0] ctrl_reg;
  reg [31:0] trim_reg;
  reg [1:0] state_reg;
  reg [31:0] cal_cnt_reg;
  reg cal_done_reg;
  reg cal_fault_reg;
  reg [7:0] cal_ofs_a_reg;
  reg [7:0] cal_ofs_b_reg;
  reg recal_prev_reg;
  reg por_hold_reg;
  reg [7:0] por_cnt_reg;
  reg [3:0] soft_cnt_reg;
  reg slip_pend_reg;
  reg div_phase_reg;
  reg core_sel_reg;
  reg sample_tick;
  reg div_two;
  reg div_illegal;
  wire recal_rise;
  wire [12:0] raw_word;
  wire [12:0] mid_word;
  wire [12:0] corr_word;
  wire [12:0] out_word;
  reg [9:0] corr_code;
  reg corr_or;
  reg signed [13:0] adj;
  reg signed [21:0] prod;
  reg [8:0] ofs_sum;

  // Offset tracking step toward midscale, saturating
  function [7:0] cal_step;
    input [7:0] cur;
    input [10:0] code;
    begin
      cal_step = cur;
      if (code > `CODE_MID && cur != `OFS_NEG_LIM) begin
        cal_step = cur - 8'h01;
      end else if (code < `CODE_MID && cur != `OFS_POS_LIM) begin
        cal_step = cur + 8'h01;
      end
    end
  endfunction

  pin_sync #(
    .W(5),
    .RESET_VAL(5'h04),
    .FAST_LOW(5'h01)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d_in({divider_select_high, divider_select_low, serial_out_line_in, supply_ok,
      recal_trigger_n_in}),
    .q_out(sync_q)
  );

  assign recal_rise = recal_lvl & ~recal_prev_reg;

  // Divider selection
  always @* begin
    div_illegal = div_high_lvl & ~div_low_lvl;
    if (ctrl_reg[`CTRL_DIV_OVR_EN]) begin
      div_two = ctrl_reg[`CTRL_DIV_OVR_TWO];
    end else begin
      div_two = div_low_lvl & ~div_high_lvl;
    end
    sample_tick = ~div_two | div_phase_reg;
  end

  // Registers, power-up detector, divider phase
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `CTRL_RESET;
      trim_reg <= `TRIM_RESET;
      rdata <= 32'h00000000;
      por_hold_reg <= 1'b1;
      por_cnt_reg <= 8'h00;
      soft_cnt_reg <= 4'h0;
      slip_pend_reg <= 1'b0;
      div_phase_reg <= 1'b0;
      recal_trigger_n_out <= 1'b0;
      recal_trigger_n_oe <= 1'b0;
      skew_trim <= 8'h00;
    end else begin
      if (wr && addr == `REG_CTRL) begin
        ctrl_reg <= {wdata[`CTRL_DIV_OVR_TWO], wdata[`CTRL_DIV_OVR_EN]};
      end
      if (wr && addr == `REG_TRIM) begin
        trim_reg <= wdata;
      end
      skew_trim <= trim_reg[`TRIM_SKEW_LSB +: 8];
      if (!supply_lvl) begin
        por_cnt_reg <= 8'h00;
        por_hold_reg <= 1'b1;
      end else if (por_cnt_reg == `POR_STABLE_CYCLES) begin
        por_hold_reg <= 1'b0;
      end else begin
        por_cnt_reg <= por_cnt_reg + 8'h01;
      end
      if (wr && addr == `REG_CTRL && wdata[`CTRL_SOFT_RECAL]) begin
        soft_cnt_reg <= `SOFT_RECAL_CYCLES;
      end else if (soft_cnt_reg != 4'h0) begin
        soft_cnt_reg <= soft_cnt_reg - 4'h1;
      end
      recal_trigger_n_out <= 1'b0;
      recal_trigger_n_oe <= ~(por_hold_reg | (soft_cnt_reg != 4'h0));
      if (wr && addr == `REG_CTRL && wdata[`CTRL_PHASE_SLIP] && div_two) begin
        slip_pend_reg <= 1'b1;
      end else if (slip_pend_reg && div_phase_reg) begin
        slip_pend_reg <= 1'b0;
      end
      if (!div_two) begin
        div_phase_reg <= 1'b0;
      end else if (!(slip_pend_reg && div_phase_reg)) begin
        div_phase_reg <= ~div_phase_reg;
      end
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          `REG_CTRL: rdata <= {30'h0, ctrl_reg};
          `REG_TRIM: rdata <= trim_reg;
          `REG_STATUS: rdata <= {25'h0, recal_lvl, ~por_hold_reg, div_two, div_illegal,
            cal_fault_reg, cal_done_reg, state_reg != ST_IDLE};
          `REG_CALOFS: rdata <= {16'h0, cal_ofs_b_reg, cal_ofs_a_reg};
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Calibration sequencer
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_HOLD;
      cal_cnt_reg <= 32'h00000000;
      cal_done_reg <= 1'b0;
      cal_fault_reg <= 1'b0;
      cal_ofs_a_reg <= 8'h00;
      cal_ofs_b_reg <= 8'h00;
      recal_prev_reg <= 1'b0;
      input_connect <= 1'b0;
    end else begin
      recal_prev_reg <= recal_lvl;
      case (state_reg)
        ST_IDLE: begin
          input_connect <= 1'b1;
          if (!recal_lvl) begin
            state_reg <= ST_HOLD;
            cal_done_reg <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (recal_rise) begin
            state_reg <= ST_RUN;
            cal_cnt_reg <= 32'h00000000;
            cal_fault_reg <= ~sdo_lvl;
            cal_ofs_a_reg <= 8'h00;
            cal_ofs_b_reg <= 8'h00;
            input_connect <= 1'b0;
          end
        end
        ST_RUN: begin
          if (!recal_lvl) begin
            state_reg <= ST_HOLD;
          end else if (cal_cnt_reg >= CAL_NOM_CYCLES - 1 ||
            cal_cnt_reg >= CAL_MAX_CYCLES - 1) begin
            state_reg <= ST_IDLE;
            cal_done_reg <= 1'b1;
            input_connect <= 1'b1;
          end else begin
            cal_cnt_reg <= cal_cnt_reg + 32'h00000001;
          end
          if (conv_valid && !cal_fault_reg) begin
            if (conv_core) begin
              cal_ofs_b_reg <= cal_step(cal_ofs_b_reg, conv_code);
            end else begin
              cal_ofs_a_reg <= cal_step(cal_ofs_a_reg, conv_code);
            end
          end
        end
        default: state_reg <= ST_HOLD;
      endcase
    end
  end

  // Interleave strobes and output clock
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_sel_reg <= 1'b0;
      core_a_strobe <= 1'b0;
      core_b_strobe <= 1'b0;
      output_clock_pair <= 1'b0;
    end else begin
      core_a_strobe <= sample_tick & ~core_sel_reg;
      core_b_strobe <= sample_tick & core_sel_reg;
      if (sample_tick) begin
        core_sel_reg <= ~core_sel_reg;
      end
      if (!recal_lvl) begin
        output_clock_pair <= 1'b0;
      end else if (sample_tick) begin
        output_clock_pair <= ~output_clock_pair;
      end
    end
  end

  assign raw_word = {conv_valid, conv_core, conv_code};

  latency_pipe #(
    .W(13),
    .DEPTH(`PIPE_SAMPLES)
  ) u_pipe_conv (
    .core_clk(core_clk),
    .rstn(rstn),
    .d_in(raw_word),
    .d_out(mid_word)
  );

  // Error correction: offset, gain on core B, saturation
  always @* begin
    if (mid_word[11]) begin
      ofs_sum = cal_ofs_b_reg + trim_reg[`TRIM_OFS_B_LSB +: 8];
    end else begin
      ofs_sum = cal_ofs_a_reg + trim_reg[`TRIM_OFS_A_LSB +: 8];
    end
    adj = $signed({3'b000, mid_word[10:0]}) + $signed({{6{ofs_sum[7]}}, ofs_sum[7:0]});
    prod = (adj - 14'sd512) * $signed(trim_reg[`TRIM_GAIN_LSB +: 8]);
    if (mid_word[11]) begin
      adj = adj + $signed(prod[21:9]);
    end
    corr_or = 1'b0;
    if (adj < 14'sd0) begin
      corr_code = 10'h000;
    end else if (adj >= $signed({4'b0000, `CODE_FULL})) begin
      corr_code = `CODE_FULL;
      corr_or = 1'b1;
    end else begin
      corr_code = adj[9:0];
    end
  end

  assign corr_word = {mid_word[12], corr_or, 1'b0, corr_code};

  latency_pipe #(
    .W(13),
    .DEPTH(`PIPE_TOTAL - `PIPE_SAMPLES - 1)
  ) u_pipe_corr (
    .core_clk(core_clk),
    .rstn(rstn),
    .d_in(corr_word),
    .d_out(out_word)
  );

  // Output stage, fifteenth edge
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sample_out <= 10'h000;
      sample_valid <= 1'b0;
      over_range <= 1'b1;
    end else begin
      sample_out <= out_word[9:0];
      sample_valid <= out_word[12] & recal_lvl & (state_reg == ST_IDLE);
      if (!recal_lvl || state_reg != ST_IDLE) begin
        over_range <= 1'b1;
      end else if (out_word[12]) begin
        over_range <= out_word[11];
      end
    end
  end
endmodule // adc_cal_control

// ### logic/latency_pipe.v
// Fixed-depth delay line for conversion words
`timescale 1ns/1ps
module latency_pipe #(
  parameter W = 13,
  parameter DEPTH = 12
) (
  input wire core_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire [W-1:0] d_in, // Word entering
  output wire [W-1:0] d_out // Word after DEPTH edges
);
  reg [W-1:0] stage_mem [0:DEPTH-1];
  integer i;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        stage_mem[i] <= {W{1'b0}};
      end
    end else begin
      stage_mem[0] <= d_in;
      for (i = 1; i < DEPTH; i = i + 1) begin
        stage_mem[i] <= stage_mem[i-1];
      end
    end
  end

  assign d_out = stage_mem[DEPTH-1];
endmodule // latency_pipe

// ### logic/pin_sync.v
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 1,
  parameter [W-1:0] RESET_VAL = {W{1'b0}},
  parameter [W-1:0] FAST_LOW = {W{1'b0}}
) (
  input wire core_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire [W-1:0] d_in, // Raw pin levels
  output wire [W-1:0] q_out // Filtered levels
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  reg [W-1:0] q_reg;
  integer i;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q_reg <= RESET_VAL;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        // Low on a fast bit taken at once, keeps one-cycle pulses
        if (s2_reg[i] == s3_reg[i] || (FAST_LOW[i] && !s3_reg[i])) begin
          q_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign q_out = q_reg;
endmodule // pin_sync
